// file: src/mfl_fault_cell.sv
// One latched fault flag with acknowledge and automatic clear
`timescale 1ns/10ps
module mfl_fault_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Live condition and clears
  input  wire logic cond,
  input  wire logic ack,
  input  wire logic auto_clr,
  // Latch state
  output logic      latched_ff,
  output logic      new_evt
);

  // Live condition has priority, so an event in the clear cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_ff <= 1'b0;
    end else if (cond) begin
      latched_ff <= 1'b1;
    end else if (ack || auto_clr) begin
      latched_ff <= 1'b0;
    end
  end

  assign new_evt = cond && !latched_ff;

endmodule

// file: src/mfl_fault_latch.sv
// Fault latch, acknowledge, history and summary indication of the motor controller
//
// What this block does
// - Any detected trip sets a latched flag instead of following the live condition.
// - A latched trip stays after its cause ends until acknowledged; a warning clears once its condition ends.
// - Auto acknowledge off by default; trips clear only by panel, fieldbus or input.
// - Auto acknowledge on: a trip clears itself once its condition has ended.
// - Keep the last 16 faults with seconds since power-on; drop the oldest.
// - History and time base are empty after power-up.
// - Relay and lamp outputs signal summary fault, selected by configuration.
// - Red fault LED lights on a trip, not on a warning, and stays until acknowledged.
// - Fieldbus telegram fault flag is one while a trip is latched.
// - Issue diagnosis message with fault details when the fieldbus supports it and no earlier message still waits to be taken.
// - Thermal overload trip reports code 0.
// - Phase loss reports code 1.
// - Phase imbalance reports code 2.
// - Locked rotor reports code 3.
// - Thermal model warning level reports warning code 4.
// - Thermistor overtemperature reports code 5.
// - Code 6 sums thermistor wiring, code 7 check-back, each with detail code.
// - Low current reports code 8 at trip and code 9 at warning.
// - High current reports code 10 at trip and code 11 at warning.
// - Each acknowledge clears the displayed fault whose condition has ended and shows the next pending one.
`timescale 1ns/10ps
module mfl_fault_latch
  import mfl_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Live fault conditions, bit index is the fault code
  input  wire logic [NUM_CODES-1:0]  fault_cond,
  input  wire logic [DETAIL_W-1:0]   ptc_wiring_detail,
  input  wire logic [DETAIL_W-1:0]   checkback_detail,
  // Acknowledge sources
  input  wire logic                  panel_ack,
  input  wire logic                  fieldbus_ack,
  input  wire logic [NUM_MFI-1:0]    multifunction_inputs,
  input  wire logic [NUM_MFI-1:0]    mfi_ack_enable,
  // Configuration
  input  wire logic                  auto_ack_enable,
  input  wire logic [1:0]            fault_output_cfg,
  input  wire logic                  diag_supported,
  // Summary indications
  output logic                       summary_fault_relay_output,
  output logic                       summary_fault_lamp_output,
  output logic                       fault_led,
  output logic                       fieldbus_fault_bit,
  // Present faults
  output logic [NUM_CODES-1:0]       latched_faults,
  output logic                       disp_valid,
  output logic [CODE_W-1:0]          disp_code,
  // Diagnosis message
  output logic                       diag_valid,
  input  wire logic                  diag_ready,
  output logic [CODE_W-1:0]          diag_code,
  output logic [DETAIL_W-1:0]        diag_detail,
  output logic [TIME_W-1:0]          diag_time,
  // History read port, index 0 is the newest entry
  input  wire logic [HIST_IDX_W-1:0] hist_rd_idx,
  output logic                       hist_rd_valid,
  output logic [CODE_W-1:0]          hist_rd_code,
  output logic [TIME_W-1:0]          hist_rd_time,
  output logic [HIST_CNT_W-1:0]      hist_count,
  output logic [TIME_W-1:0]          uptime_seconds
);

  logic [NUM_CODES-1:0]  latched_vec;
  logic [NUM_CODES-1:0]  new_vec;
  logic [NUM_CODES-1:0]  ack_vec;
  logic [NUM_CODES-1:0]  auto_vec;
  logic [NUM_CODES-1:0]  pend_ff;
  logic [NUM_CODES-1:0]  rec_onehot;
  logic [NUM_MFI-1:0]    mfi_prev_ff;
  logic [CODE_W-1:0]     disp_idx;
  logic [CODE_W-1:0]     rec_idx;
  logic                  rec_en;
  logic                  ack_any;
  logic                  any_trip;
  logic [31:0]           sec_div_ff;
  logic [TIME_W-1:0]     uptime_ff;
  logic [CODE_W-1:0]     hist_code_ff [HIST_DEPTH];
  logic [TIME_W-1:0]     hist_time_ff [HIST_DEPTH];
  logic [HIST_IDX_W-1:0] wr_ptr_ff;
  logic [HIST_CNT_W-1:0] count_ff;
  logic [HIST_IDX_W-1:0] rd_addr;
  logic                  hist_rd_valid_ff;
  logic [CODE_W-1:0]     hist_rd_code_ff;
  logic [TIME_W-1:0]     hist_rd_time_ff;
  mfl_diag_state_type    diag_state_ff;
  logic [CODE_W-1:0]     diag_code_ff;
  logic [DETAIL_W-1:0]   diag_detail_ff;
  logic [TIME_W-1:0]     diag_time_ff;

  // Multifunction inputs acknowledge on their rising edge only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mfi_prev_ff <= '0;
    end else begin
      mfi_prev_ff <= multifunction_inputs;
    end
  end

  assign ack_any = panel_ack || fieldbus_ack ||
                   (|(multifunction_inputs & ~mfi_prev_ff & mfi_ack_enable));

  // Displayed fault is the lowest pending code
  always_comb begin
    disp_idx = '0;
    for (int i = NUM_CODES - 1; i >= 0; i--) begin
      if (latched_vec[i]) begin
        disp_idx = CODE_W'(i);
      end
    end
  end

  // Acknowledge clears only the displayed fault; the next one then shows
  always_comb begin
    ack_vec = '0;
    if (ack_any && disp_valid) begin
      ack_vec[disp_idx] = 1'b1;
    end
  end

  // Warnings follow their condition once it ends; trips wait unless auto is on
  assign auto_vec = (~TRIP_MASK) | (auto_ack_enable ? TRIP_MASK : '0);

  // Bit index equals the reported code
  generate
    for (genvar g = 0; g < NUM_CODES; g++) begin : g_cell
      mfl_fault_cell u_cell (
        .clk        (clk),
        .rst_n      (rst_n),
        .cond       (fault_cond[g]),
        .ack        (ack_vec[g]),
        .auto_clr   (auto_vec[g]),
        .latched_ff (latched_vec[g]),
        .new_evt    (new_vec[g])
      );
    end
  endgenerate

  // Summary indications, same-cycle drop with the last trip
  assign any_trip                   = |(latched_vec & TRIP_MASK);
  assign summary_fault_relay_output = any_trip && fault_output_cfg[FOUT_RELAY_BIT];
  assign summary_fault_lamp_output  = any_trip && fault_output_cfg[FOUT_LAMP_BIT];
  assign fault_led                  = any_trip;
  assign fieldbus_fault_bit         = any_trip;
  assign latched_faults             = latched_vec;
  assign disp_valid                 = |latched_vec;
  assign disp_code                  = disp_idx;

  // Seconds since power-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_div_ff <= '0;
      uptime_ff  <= TIME_RST;
    end else if (sec_div_ff == SEC_CYCLES - 1) begin
      sec_div_ff <= '0;
      uptime_ff  <= uptime_ff + 32'h0000_0001;
    end else begin
      sec_div_ff <= sec_div_ff + 32'h0000_0001;
    end
  end

  assign uptime_seconds = uptime_ff;

  // Simultaneous new faults are queued and written one per cycle
  always_comb begin
    rec_idx = '0;
    for (int i = NUM_CODES - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        rec_idx = CODE_W'(i);
      end
    end
  end

  assign rec_en = |pend_ff;

  always_comb begin
    rec_onehot = '0;
    if (rec_en) begin
      rec_onehot[rec_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= LATCH_RST;
    end else begin
      pend_ff <= (pend_ff & ~rec_onehot) | new_vec;
    end
  end

  // Ring of 16 entries; the oldest is overwritten when full
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= PTR_RST;
      count_ff  <= CNT_RST;
    end else if (rec_en) begin
      wr_ptr_ff <= wr_ptr_ff + 4'h1;
      if (count_ff != HIST_CNT_W'(HIST_DEPTH)) begin
        count_ff <= count_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_code_ff[i] <= '0;
        hist_time_ff[i] <= TIME_RST;
      end
    end else if (rec_en) begin
      hist_code_ff[wr_ptr_ff] <= rec_idx;
      hist_time_ff[wr_ptr_ff] <= uptime_ff;
    end
  end

  // Read port, one cycle of latency
  assign rd_addr = wr_ptr_ff - 4'h1 - hist_rd_idx;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_rd_valid_ff <= 1'b0;
      hist_rd_code_ff  <= '0;
      hist_rd_time_ff  <= TIME_RST;
    end else begin
      hist_rd_valid_ff <= {1'b0, hist_rd_idx} < count_ff;
      hist_rd_code_ff  <= hist_code_ff[rd_addr];
      hist_rd_time_ff  <= hist_time_ff[rd_addr];
    end
  end

  assign hist_rd_valid = hist_rd_valid_ff;
  assign hist_rd_code  = hist_rd_code_ff;
  assign hist_rd_time  = hist_rd_time_ff;
  assign hist_count    = count_ff;

  // Diagnosis sender; a fault recorded while busy gets no message, only history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_state_ff  <= DIAG_IDLE;
      diag_code_ff   <= '0;
      diag_detail_ff <= '0;
      diag_time_ff   <= TIME_RST;
    end else begin
      unique case (diag_state_ff)
        DIAG_IDLE: begin
          if (rec_en && diag_supported) begin
            diag_state_ff <= DIAG_SEND;
            diag_code_ff  <= rec_idx;
            diag_time_ff  <= uptime_ff;
            if (rec_idx == CODE_PTC_WIRING) begin
              diag_detail_ff <= ptc_wiring_detail;
            end else if (rec_idx == CODE_CHECKBACK) begin
              diag_detail_ff <= checkback_detail;
            end else begin
              diag_detail_ff <= '0;
            end
          end
        end
        DIAG_SEND: begin
          if (diag_ready) begin
            diag_state_ff <= DIAG_IDLE;
          end
        end
        default: begin
          diag_state_ff <= DIAG_IDLE;
        end
      endcase
    end
  end

  assign diag_valid  = diag_state_ff == DIAG_SEND;
  assign diag_code   = diag_code_ff;
  assign diag_detail = diag_detail_ff;
  assign diag_time   = diag_time_ff;

  AST_LATCH_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_cond != '0) |=> ((latched_vec & $past(fault_cond)) == $past(fault_cond)))
    else $error("live fault not latched");

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (!ack_any && !auto_ack_enable) |=>
      ((latched_vec & $past(latched_vec) & TRIP_MASK) == ($past(latched_vec) & TRIP_MASK)))
    else $error("trip cleared without acknowledge");

  AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (auto_ack_enable && ((latched_vec & ~fault_cond & TRIP_MASK) != '0)) |=>
      ((latched_vec & $past(latched_vec & ~fault_cond & TRIP_MASK)) == '0))
    else $error("trip not auto cleared");

  // Other bits may only move by their own set or automatic clear
  AST_ACK_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
    (ack_any && disp_valid && !fault_cond[disp_idx]) |=>
      (!latched_vec[$past(disp_idx)] &&
       (((latched_vec ^ $past(latched_vec)) & ~$past(auto_vec | fault_cond)) ==
        ((12'h001 << $past(disp_idx)) & ~$past(auto_vec | fault_cond)))))
    else $error("acknowledge did not clear displayed fault");

  AST_HIST_GROW: assert property (@(posedge clk) disable iff (!rst_n)
    (rec_en && count_ff < HIST_CNT_W'(HIST_DEPTH)) |=>
      (count_ff == $past(count_ff) + 5'h01 && hist_code_ff[$past(wr_ptr_ff)] == $past(rec_idx)))
    else $error("history entry not recorded");

  AST_HIST_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    count_ff <= HIST_CNT_W'(HIST_DEPTH))
    else $error("history count above depth");

  AST_SECONDS: assert property (@(posedge clk) disable iff (!rst_n)
    (sec_div_ff == SEC_CYCLES - 1) |=> (uptime_ff == $past(uptime_ff) + 32'h0000_0001))
    else $error("seconds counter did not advance");

  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(any_trip) |-> ((latched_vec & TRIP_MASK) == '0 && !fault_led &&
      !fieldbus_fault_bit && !summary_fault_relay_output && !summary_fault_lamp_output)))
    else $error("summary indication still on after last trip");

  AST_LED_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_led && !ack_any && !auto_ack_enable) |=> fault_led)
    else $error("fault LED dropped without acknowledge");

  AST_DIAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (diag_valid && !diag_ready) |=> (diag_valid && $stable(diag_code) && $stable(diag_detail)))
    else $error("diagnosis message changed before taken");

  AST_DIAG_START: assert property (@(posedge clk) disable iff (!rst_n)
    (rec_en && diag_supported && !diag_valid) |=> (diag_valid && diag_code == $past(rec_idx)))
    else $error("diagnosis message not issued");

  AST_LED_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ((fault_cond & TRIP_MASK) != '0) |=> fault_led)
    else $error("fault LED not lit on trip");

  AST_WARN_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    ((latched_vec & ~fault_cond & ~TRIP_MASK) != '0) |=>
      ((latched_vec & $past(latched_vec & ~fault_cond & ~TRIP_MASK)) == '0))
    else $error("warning stayed after its condition ended");

  AST_HIST_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
    ({1'b0, hist_rd_idx} >= count_ff) |=> !hist_rd_valid)
    else $error("history read of an empty slot flagged valid");

endmodule

// file: src/mfl_pkg.sv
// Constants and types shared by the fault latch manager
package mfl_pkg;

  // Code space and storage sizes
  localparam int NUM_CODES  = 12;
  localparam int CODE_W     = 4;
  localparam int HIST_DEPTH = 16;
  localparam int HIST_IDX_W = 4;
  localparam int HIST_CNT_W = 5;
  localparam int TIME_W     = 32;
  localparam int DETAIL_W   = 8;
  localparam int NUM_MFI    = 3;

  // Fault and warning codes
  localparam logic [CODE_W-1:0] CODE_THERMAL_TRIP = 4'h0;
  localparam logic [CODE_W-1:0] CODE_PHASE_LOSS   = 4'h1;
  localparam logic [CODE_W-1:0] CODE_PHASE_IMBAL  = 4'h2;
  localparam logic [CODE_W-1:0] CODE_LOCKED_ROTOR = 4'h3;
  localparam logic [CODE_W-1:0] CODE_THERMAL_WARN = 4'h4;
  localparam logic [CODE_W-1:0] CODE_PTC_OVERTEMP = 4'h5;
  localparam logic [CODE_W-1:0] CODE_PTC_WIRING   = 4'h6;
  localparam logic [CODE_W-1:0] CODE_CHECKBACK    = 4'h7;
  localparam logic [CODE_W-1:0] CODE_LOW_CUR_TRIP = 4'h8;
  localparam logic [CODE_W-1:0] CODE_LOW_CUR_WARN = 4'h9;
  localparam logic [CODE_W-1:0] CODE_HI_CUR_TRIP  = 4'ha;
  localparam logic [CODE_W-1:0] CODE_HI_CUR_WARN  = 4'hb;

  // Codes 0,1,2,3,5,6,7,8,10 are trips; 4,9,11 are warnings
  localparam logic [NUM_CODES-1:0] TRIP_MASK = 12'h5ef;

  // Fault output configuration field positions
  localparam int FOUT_RELAY_BIT = 0;
  localparam int FOUT_LAMP_BIT  = 1;

  // Reset values
  localparam logic [NUM_CODES-1:0]  LATCH_RST = 12'h000;
  localparam logic [TIME_W-1:0]     TIME_RST  = 32'h0000_0000;
  localparam logic [HIST_CNT_W-1:0] CNT_RST   = 5'h00;
  localparam logic [HIST_IDX_W-1:0] PTR_RST   = 4'h0;

  // Time base
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SECOND_NS       = 1_000_000_000;
  localparam int SEC_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;

  // Diagnosis message sender
  typedef enum logic [1:0] {
    DIAG_IDLE = 2'b01,
    DIAG_SEND = 2'b10
  } mfl_diag_state_type;

endpackage

// file: tb/mfl_diag_sink.sv
// Diagnosis message sink standing in for the fieldbus master
`timescale 1ns/10ps
module mfl_diag_sink
  import mfl_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Message handshake
  input  wire logic                       diag_valid,
  input  wire logic [CODE_W-1:0]          diag_code,
  input  wire logic [DETAIL_W-1:0]        diag_detail,
  output logic                            diag_ready,
  // Answer latency in cycles
  input  wire logic [1:0]                 lat,
  // Taken message, stands one cycle
  output logic                            got,
  output logic [CODE_W+DETAIL_W-1:0]      got_msg
);
  logic [1:0] wait_ff;

  // Ready only after the chosen wait, so slow masters are covered too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_ready <= 1'b0;
      wait_ff    <= 2'h0;
      got        <= 1'b0;
      got_msg    <= '0;
    end else begin
      got <= diag_valid && diag_ready;
      if (diag_valid && diag_ready) begin
        diag_ready <= 1'b0;
        wait_ff    <= 2'h0;
        got_msg    <= {diag_code, diag_detail};
      end else if (diag_valid) begin
        wait_ff    <= wait_ff + 2'h1;
        diag_ready <= (wait_ff >= lat);
      end
    end
  end
endmodule

// file: tb/mfl_fault_latch_tb.sv
// Self-checking bench of the fault latch manager
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mfl_fault_latch_tb;
  import mfl_pkg::*;
  localparam int SEC = 10;
  logic clk, rst_n, panel_ack, fieldbus_ack, auto_ack_enable, diag_supported;
  logic [NUM_CODES-1:0] fault_cond, latched_faults;
  logic [DETAIL_W-1:0] ptc_d, chk_d, diag_detail;
  logic [NUM_MFI-1:0] mfi, mfi_en;
  logic [1:0] fault_output_cfg, lat;
  logic relay, lamp, fault_led, fb_bit, disp_valid, diag_valid, diag_ready;
  logic hist_rd_valid, got;
  logic [CODE_W-1:0] disp_code, diag_code, hist_rd_code;
  logic [TIME_W-1:0] diag_time, hist_rd_time, uptime, u0;
  logic [HIST_IDX_W-1:0] hist_rd_idx;
  logic [HIST_CNT_W-1:0] hist_count;
  logic [CODE_W+DETAIL_W-1:0] got_msg;
  logic [31:0] seed = 32'hfc181de4;
  logic [TIME_W+CODE_W+DETAIL_W-1:0] dq[$];
  logic [TIME_W+CODE_W+DETAIL_W-1:0] exp_msg;
  logic [TIME_W+CODE_W-1:0] hq[$];
  int cyc;
  int failures = 0;
  int check_count = 0;

  mfl_fault_latch #(.SEC_CYCLES(SEC)) mfl_fault_latch_inst (
    .clk(clk), .rst_n(rst_n), .fault_cond(fault_cond), .ptc_wiring_detail(ptc_d),
    .checkback_detail(chk_d), .panel_ack(panel_ack), .fieldbus_ack(fieldbus_ack),
    .multifunction_inputs(mfi), .mfi_ack_enable(mfi_en), .auto_ack_enable(auto_ack_enable),
    .fault_output_cfg(fault_output_cfg), .diag_supported(diag_supported),
    .summary_fault_relay_output(relay), .summary_fault_lamp_output(lamp),
    .fault_led(fault_led), .fieldbus_fault_bit(fb_bit), .latched_faults(latched_faults),
    .disp_valid(disp_valid), .disp_code(disp_code), .diag_valid(diag_valid),
    .diag_ready(diag_ready), .diag_code(diag_code), .diag_detail(diag_detail),
    .diag_time(diag_time), .hist_rd_idx(hist_rd_idx), .hist_rd_valid(hist_rd_valid),
    .hist_rd_code(hist_rd_code), .hist_rd_time(hist_rd_time), .hist_count(hist_count),
    .uptime_seconds(uptime));

  mfl_diag_sink mfl_diag_sink_inst (
    .clk(clk), .rst_n(rst_n), .diag_valid(diag_valid), .diag_code(diag_code),
    .diag_detail(diag_detail), .diag_ready(diag_ready), .lat(lat), .got(got),
    .got_msg(got_msg));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Seconds since reset release, as an entry written d+1 edges later is stamped
  function automatic logic [TIME_W-1:0] now_s(input int d);
    return TIME_W'((cyc + d) / SEC);
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Panel, fieldbus, then multifunction input k as source 2+k
  task automatic ack(input int s);
    @(posedge clk);
    if (s == 0) panel_ack <= 1'b1;
    else if (s == 1) fieldbus_ack <= 1'b1;
    else mfi[s-2] <= 1'b1;
    @(posedge clk);
    panel_ack    <= 1'b0;
    fieldbus_ack <= 1'b0;
    mfi          <= '0;
    @(negedge clk);
  endtask

  task automatic hchk(input int k);
    @(posedge clk);
    hist_rd_idx <= HIST_IDX_W'(k);
    @(posedge clk);
    @(negedge clk);
    `CHK(hist_rd_valid, k < hq.size())
    if (k < hq.size()) `CHK({hist_rd_time, hist_rd_code}, hq[hq.size()-1-k])
  endtask

  // Messages must be handed over in bounded time
  task automatic drain(input string name);
    for (int i = 0; i < 50 && dq.size() > 0; i++) @(posedge clk);
    if (dq.size() > 0) begin
      failures++;
      $display("CHECK FAILED t=%0t diagnosis wait ran out", $time);
      test_done();
    end else begin
      $display("test %s done", name);
    end
  endtask

  // Each taken message is matched against the oldest note
  always @(negedge clk) begin
    if (got === 1'b1) begin
      if (dq.size() == 0) begin
        `CHK(got_msg, 12'hfff)
      end else begin
        // Pop once; the macro reads its operands twice
        exp_msg = dq.pop_front();
        `CHK({diag_time, got_msg}, exp_msg)
      end
    end
  end

  initial begin
    logic [1:0] cfg;
    logic [DETAIL_W-1:0] det;
    rst_n = 1'b0;
    {panel_ack, fieldbus_ack, auto_ack_enable, diag_supported} = 4'h1;
    fault_cond = '0;
    {ptc_d, chk_d} = 16'h0000;
    {mfi, mfi_en} = 6'h00;
    {fault_output_cfg, lat} = 4'h0;
    hist_rd_idx = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({latched_faults, hist_count, uptime, fault_led}, '0)
    hchk(0);
    // Every code, random output configuration and partner latency
    for (int n = 0; n < NUM_CODES; n++) begin
      cfg = 2'(rnd());
      @(posedge clk);
      fault_output_cfg <= cfg;
      lat              <= 2'(rnd());
      ptc_d            <= DETAIL_W'(rnd());
      chk_d            <= DETAIL_W'(rnd());
      fault_cond       <= 12'h001 << n;
      @(posedge clk);
      fault_cond <= '0;
      @(negedge clk);
      det = (n == 6) ? ptc_d : (n == 7) ? chk_d : 8'h00;
      dq.push_back({now_s(0), CODE_W'(n), det});
      hq.push_back({now_s(0), CODE_W'(n)});
      `CHK(latched_faults, 12'h001 << n)
      `CHK({disp_valid, disp_code}, {1'b1, CODE_W'(n)})
      `CHK({fault_led, fb_bit}, {2{TRIP_MASK[n]}})
      `CHK({lamp, relay}, cfg & {2{TRIP_MASK[n]}})
      @(negedge clk);
      `CHK(latched_faults[n], TRIP_MASK[n])
      if (TRIP_MASK[n]) ack(n % 2);
      `CHK({latched_faults, fault_led}, '0)
      drain("codes");
    end
    `CHK(hist_count, 5'h0c)
    hchk(12);
    u0 = uptime;
    repeat (10 * SEC) @(posedge clk);
    @(negedge clk);
    `CHK(uptime - u0, 32'h0000_000a)
    // Pending faults are taken one by one, no message without support
    @(posedge clk);
    diag_supported   <= 1'b0;
    fault_output_cfg <= 2'h3;
    fault_cond       <= 12'h421;
    @(posedge clk);
    fault_cond <= 12'h400;
    @(negedge clk);
    // Queued entries go out one per edge, lowest code first
    hq.push_back({now_s(0), 4'h0});
    hq.push_back({now_s(1), 4'h5});
    hq.push_back({now_s(2), 4'ha});
    `CHK(disp_code, 4'h0)
    ack(0);
    `CHK({latched_faults, disp_code}, {12'h420, 4'h5})
    ack(1);
    `CHK({latched_faults, disp_code}, {12'h400, 4'ha})
    ack(0);
    `CHK(latched_faults, 12'h400)
    @(posedge clk);
    fault_cond <= '0;
    ack(2);
    `CHK(latched_faults, 12'h400)
    @(posedge clk);
    mfi_en <= 3'h2;
    ack(3);
    `CHK({latched_faults, disp_valid, relay, lamp, fault_led, fb_bit}, '0)
    drain("pending");
    // Automatic acknowledge, set wins while the condition stands
    @(posedge clk);
    diag_supported  <= 1'b1;
    auto_ack_enable <= 1'b1;
    fault_cond      <= 12'h008;
    @(posedge clk);
    @(negedge clk);
    dq.push_back({now_s(0), 4'h3, 8'h00});
    hq.push_back({now_s(0), 4'h3});
    repeat (2) @(posedge clk);
    fault_cond <= '0;
    @(negedge clk);
    `CHK({latched_faults[3], fault_led}, 2'h3)
    @(negedge clk);
    `CHK({latched_faults[3], fault_led}, 2'h0)
    drain("auto");
    // Seventeenth entry pushes out the oldest
    @(posedge clk);
    auto_ack_enable <= 1'b0;
    fault_cond      <= 12'h002;
    @(posedge clk);
    fault_cond <= '0;
    @(negedge clk);
    dq.push_back({now_s(0), 4'h1, 8'h00});
    hq.push_back({now_s(0), 4'h1});
    void'(hq.pop_front());
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(hist_count, 5'h10)
    for (int k = 0; k < HIST_DEPTH; k++) hchk(k);
    drain("history");
    // Power loss in mid-run empties history and time base
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({latched_faults, hist_count, uptime, fault_led}, '0)
    hq.delete();
    hchk(0);
    $display("test power_loss done");
    test_done();
  end
endmodule
